// File: sidc_top.sv
// Indicator lights, text display selection and error recovery with APB registers
//
// Operation
// - Six lights, lights 1-3 show channel A, lights 4-6 show channel B.
// - Bicolor light dark unpowered, red outputs off, flashing on error, green on.
// - Yellow off without interlock, flashing when field occupied, steady when blocked.
// - Blue light on while the warning field is interrupted.
// - Normal operation shows the monitored field pair on the display.
// - Unconfigured boot cycles identity items and request banner, then angles.
// - Configured boot cycles identity, date, signature, angles, then normal view.
// - Pending banner until download confirmed, then active banner during transfer.
// - Identification request shows identify banner with device name.
// - Diagnostic shows class letter F, E, U, I or P and a code.
// - Non-locking errors recover after ten seconds without restarting the machine.
// - Blocking errors lock until power is removed and reapplied.
// - After field free about five seconds display returns to normal.
// - Settings blank the display or rotate it by 180 degrees.
// - Messages name channel or device, followed by code.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
module sidc_top #(
   parameter logic [31:0] REC_CYCLES   = sidc_pkg::REC_CYC,
   parameter logic [31:0] FREE_CYCLES  = sidc_pkg::FREE_CYC,
   parameter logic [31:0] BLINK_CYCLES = sidc_pkg::BLINK_CYC,
   parameter logic [31:0] ITEM_CYCLES  = sidc_pkg::ITEM_CYC
) (
   input  wire logic                     clk_sys,
   input  wire logic                     rst,
   input  wire logic [7:0]               paddr,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic [sidc_pkg::NCH-1:0] chanOn,
   input  wire logic [sidc_pkg::NCH-1:0] safeOutOn,
   input  wire logic [sidc_pkg::NCH-1:0] chanErr,
   input  wire logic [sidc_pkg::NCH-1:0] interlockOn,
   input  wire logic [sidc_pkg::NCH-1:0] interlockBlocked,
   input  wire logic [sidc_pkg::NCH-1:0] protOcc,
   input  wire logic [sidc_pkg::NCH-1:0] warnOcc,
   input  wire logic [7:0]               pairA,
   input  wire logic [7:0]               pairB,
   input  wire logic [7:0]               angleH,
   input  wire logic [7:0]               angleV,
   input  wire logic                     bootDone,
   input  wire logic                     cfgPresent,
   input  wire logic                     xferPending,
   input  wire logic                     xferConfirmed,
   input  wire logic                     xferActive,
   input  wire logic                     pingReq,
   input  wire logic                     diagValid,
   input  wire logic [2:0]               diagClass,
   input  wire logic [9:0]               diagCode,
   input  wire logic [1:0]               diagOrigin,
   input  wire logic                     diagLocking,
   output logic      [sidc_pkg::NCH-1:0] ledRed,
   output logic      [sidc_pkg::NCH-1:0] ledGreen,
   output logic      [sidc_pkg::NCH-1:0] ledYellow,
   output logic      [sidc_pkg::NCH-1:0] ledBlue,
   output logic      [3:0]               dispSrc,
   output logic      [15:0]              dispArg,
   output logic                          dispBlank,
   output logic                          dispRotate,
   output logic                          recoverReq,
   output logic                          irq
);
   import sidc_pkg::*;

   logic [1:0]        ctrl_reg;
   logic [IRQ_W-1:0]  irqStat_reg;
   logic [IRQ_W-1:0]  irqMask_reg;
   logic [IRQ_W-1:0]  irqSet;
   logic [IRQ_W-1:0]  irqClr;
   logic              lock_reg;
   logic              errActive_reg;
   logic              msgShow_reg;
   logic [2:0]        class_reg;
   logic [9:0]        code_reg;
   logic [1:0]        origin_reg;
   logic [31:0]       recCnt_reg;
   logic [31:0]       freeCnt_reg;
   logic [31:0]       blinkCnt_reg;
   logic              blink_reg;
   logic [31:0]       itemCnt_reg;
   logic [3:0]        bootIdx_reg;
   logic [31:0]       pingCnt_reg;
   sidc_state_t       state_reg;
   logic              access;
   logic              wrDone;
   logic              hit;
   logic [31:0]       rdMux;
   logic              recFire;
   logic              freeDone;
   logic              newDiag;
   logic              pingShow;
   logic [3:0]        bootSrc;
   logic [3:0]        src_next;
   logic [15:0]       arg_next;
   logic [NCH-1:0]    faulted;

   // First access cycle; the answer follows one cycle later
   assign access = psel & penable & ~pready;
   assign wrDone = psel & penable & pready & pwrite;

   // Address decode and read data
   always_comb begin
      hit   = 1'b1;
      rdMux = 32'h0;
      case (paddr)
         OFS_CTRL: rdMux = {30'h0, ctrl_reg};
         OFS_STAT: rdMux = {24'h0, dispSrc, 1'b0, (state_reg == SIDC_BOOT), errActive_reg, lock_reg};
         OFS_IRQS: rdMux = {28'h0, irqStat_reg};
         OFS_IRQM: rdMux = {28'h0, irqMask_reg};
         OFS_DIAG: rdMux = {17'h0, origin_reg, class_reg, code_reg};
         default:  hit = 1'b0;
      endcase
   end

   // APB answer, registered so every output stays a flop
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= access;
         pslverr <= access & ~hit;
         prdata  <= (access & ~pwrite) ? rdMux : 32'h0;
      end
   end

   // Control and mask registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_reg    <= CTRL_RST;
         irqMask_reg <= IRQM_RST;
      end else if (wrDone) begin
         if (paddr == OFS_CTRL) begin
            ctrl_reg <= pwdata[1:0];
         end
         if (paddr == OFS_IRQM) begin
            irqMask_reg <= pwdata[IRQ_W-1:0];
         end
      end
   end

   // Sticky events, a set in the clearing cycle wins
   assign irqClr = (wrDone && paddr == OFS_IRQS) ? pwdata[IRQ_W-1:0] : '0;
   always_comb begin
      irqSet           = '0;
      irqSet[IRQ_DIAG] = diagValid;
      irqSet[IRQ_LOCK] = newDiag & diagLocking;
      irqSet[IRQ_REC]  = recFire;
      irqSet[IRQ_PING] = pingReq;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irqStat_reg <= '0;
         irq         <= 1'b0;
      end else begin
         irqStat_reg <= (irqStat_reg & ~irqClr) | irqSet;
         irq         <= |(irqStat_reg & irqMask_reg);
      end
   end

   // Once locked, later messages cannot replace the locking one
   assign newDiag = diagValid & ~lock_reg;
   assign recFire = errActive_reg & ~lock_reg & ~diagValid & (recCnt_reg == REC_CYCLES - 32'h1);
   assign freeDone = (freeCnt_reg == FREE_CYCLES - 32'h1);

   // Diagnostic capture; class and code kept for display and readback
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         class_reg  <= CLS_F;
         code_reg   <= 10'h0;
         origin_reg <= ORIG_DEV;
      end else if (newDiag) begin
         class_reg  <= diagClass;
         code_reg   <= diagCode;
         origin_reg <= diagOrigin;
      end
   end

   // Lock leaves only through reset, which stands for a power cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lock_reg <= 1'b0;
      end else if (newDiag & diagLocking) begin
         lock_reg <= 1'b1;
      end
   end

   // Recovery timer restarts on every new error
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         errActive_reg <= 1'b0;
         recCnt_reg    <= 32'h0;
         recoverReq    <= 1'b0;
      end else begin
         recoverReq <= recFire;
         if (newDiag) begin
            errActive_reg <= 1'b1;
            recCnt_reg    <= 32'h0;
         end else if (recFire) begin
            errActive_reg <= 1'b0;
            recCnt_reg    <= 32'h0;
         end else if (errActive_reg & ~lock_reg) begin
            recCnt_reg <= recCnt_reg + 32'h1;
         end
      end
   end

   // Recovery only asks; outputs still need the restart interlock, so no restart
   // Free-field timer saturates, any occupied channel restarts it
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         freeCnt_reg <= 32'h0;
      end else if (|protOcc) begin
         freeCnt_reg <= 32'h0;
      end else if (!freeDone) begin
         freeCnt_reg <= freeCnt_reg + 32'h1;
      end
   end

   // Message stays until error gone and field free long enough
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         msgShow_reg <= 1'b0;
      end else if (newDiag) begin
         msgShow_reg <= 1'b1;
      end else if (msgShow_reg & ~errActive_reg & ~lock_reg & freeDone) begin
         msgShow_reg <= 1'b0;
      end
   end

   // Shared blink divider keeps error and occupied flashing in phase
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         blinkCnt_reg <= 32'h0;
         blink_reg    <= 1'b0;
      end else if (blinkCnt_reg == BLINK_CYCLES - 32'h1) begin
         blinkCnt_reg <= 32'h0;
         blink_reg    <= ~blink_reg;
      end else begin
         blinkCnt_reg <= blinkCnt_reg + 32'h1;
      end
   end

   // Boot phase steps through info items at a fixed dwell
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg   <= SIDC_BOOT;
         itemCnt_reg <= 32'h0;
         bootIdx_reg <= 4'h0;
      end else begin
         case (state_reg)
            SIDC_BOOT: begin
               if (bootDone) begin
                  state_reg <= SIDC_RUN;
               end else if (itemCnt_reg == ITEM_CYCLES - 32'h1) begin
                  itemCnt_reg <= 32'h0;
                  if (bootIdx_reg >= (cfgPresent ? BOOT_LAST_C : BOOT_LAST_NC)) begin
                     bootIdx_reg <= 4'h0;
                  end else begin
                     bootIdx_reg <= bootIdx_reg + 4'h1;
                  end
               end else begin
                  itemCnt_reg <= itemCnt_reg + 32'h1;
               end
            end
            SIDC_RUN: begin
               itemCnt_reg <= 32'h0;
            end
            default: begin
               state_reg <= SIDC_BOOT;
            end
         endcase
      end
   end

   // Boot item to content code; the configured list shows date in place of the request and adds signature and angles
   always_comb begin
      case (bootIdx_reg)
         BOOT_I_CFG: bootSrc = cfgPresent ? SRC_DATE : SRC_CFGREQ;
         BOOT_I_SIG: bootSrc = SRC_SIG;
         BOOT_I_LVL: bootSrc = SRC_LEVEL;
         default:    bootSrc = bootIdx_reg;
      endcase
   end

   // Identify banner holds for one item dwell after each request
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pingCnt_reg <= 32'h0;
      end else if (pingReq) begin
         pingCnt_reg <= ITEM_CYCLES;
      end else if (pingCnt_reg != 32'h0) begin
         pingCnt_reg <= pingCnt_reg - 32'h1;
      end
   end
   assign pingShow = (pingCnt_reg != 32'h0);

   // Content priority: error, banners, then boot or normal view
   always_comb begin
      src_next = SRC_PAIR;
      arg_next = {pairA, pairB};
      if (msgShow_reg) begin
         src_next = SRC_DIAG;
         arg_next = {1'b0, origin_reg, class_reg, code_reg};
      end else if (xferActive) begin
         src_next = SRC_XFER;
      end else if (xferPending & ~xferConfirmed) begin
         src_next = SRC_PEND;
      end else if (pingShow) begin
         src_next = SRC_PING;
      end else if (state_reg == SIDC_BOOT) begin
         src_next = bootSrc;
         arg_next = {angleH, angleV};
      end else if (!cfgPresent) begin
         src_next = SRC_LEVEL;
         arg_next = {angleH, angleV};
      end
   end

   // Display outputs; blank and rotate passed to the character driver
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dispSrc    <= SRC_TYPE;
         dispArg    <= 16'h0;
         dispBlank  <= 1'b0;
         dispRotate <= 1'b0;
      end else begin
         dispSrc    <= src_next;
         dispArg    <= arg_next;
         dispBlank  <= ctrl_reg[CTRL_BLANK];
         dispRotate <= ctrl_reg[CTRL_ROT];
      end
   end

   // Lights, index 0 is channel A (lights 1-3), index 1 is B (lights 6-4)
   assign faulted = chanErr | {NCH{lock_reg}};
   for (genvar ch = 0; ch < NCH; ch++) begin : g_led
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            ledRed[ch]    <= 1'b0;
            ledGreen[ch]  <= 1'b0;
            ledYellow[ch] <= 1'b0;
            ledBlue[ch]   <= 1'b0;
         end else begin
            ledRed[ch]    <= chanOn[ch] & (faulted[ch] ? blink_reg : ~safeOutOn[ch]);
            ledGreen[ch]  <= chanOn[ch] & ~faulted[ch] & safeOutOn[ch];
            ledYellow[ch] <= chanOn[ch] & interlockOn[ch] & (protOcc[ch] ? blink_reg : interlockBlocked[ch]);
            ledBlue[ch]   <= chanOn[ch] & warnOcc[ch];
         end
      end
   end

   // Checks
   a_lock_sticky: assert property (@(posedge clk_sys) disable iff (rst)
      lock_reg |=> lock_reg && !recoverReq) else $error("lock released or recovered");
   a_rec_time: assert property (@(posedge clk_sys) disable iff (rst)
      recFire |=> recoverReq && !errActive_reg && $past(recCnt_reg) == REC_CYCLES - 32'h1)
      else $error("recovery not at timeout");
   a_free_revert: assert property (@(posedge clk_sys) disable iff (rst)
      msgShow_reg && !errActive_reg && !lock_reg && !diagValid && freeDone |=> !msgShow_reg)
      else $error("display did not revert");
   a_green_on: assert property (@(posedge clk_sys) disable iff (rst)
      chanOn[0] && safeOutOn[0] && !faulted[0] |=> ledGreen[0] && !ledRed[0]) else $error("green missing");
   a_red_blink: assert property (@(posedge clk_sys) disable iff (rst)
      chanOn[0] && faulted[0] |=> !ledGreen[0] && ledRed[0] == $past(blink_reg)) else $error("error flash");
   a_yellow_occ: assert property (@(posedge clk_sys) disable iff (rst)
      chanOn[1] && interlockOn[1] && protOcc[1] |=> ledYellow[1] == $past(blink_reg))
      else $error("occupied flash");
   a_blue_warn: assert property (@(posedge clk_sys) disable iff (rst)
      ledBlue[1] |-> $past(warnOcc[1]) && $past(chanOn[1])) else $error("blue without warning");
   a_diag_first: assert property (@(posedge clk_sys) disable iff (rst)
      msgShow_reg |=> dispSrc == SRC_DIAG && dispArg[9:0] == $past(code_reg)) else $error("error not shown");
   a_xfer_banner: assert property (@(posedge clk_sys) disable iff (rst)
      !msgShow_reg && xferActive |=> dispSrc == SRC_XFER) else $error("transfer banner missing");
   a_ping_banner: assert property (@(posedge clk_sys) disable iff (rst)
      pingReq && !diagValid && !xferActive && !xferPending ##1 !msgShow_reg && !xferActive && !xferPending
      |=> dispSrc == SRC_PING) else $error("identify banner missing");
   a_pair_run: assert property (@(posedge clk_sys) disable iff (rst)
      dispSrc == SRC_PAIR |-> $past(state_reg) == SIDC_RUN && dispArg == {$past(pairA), $past(pairB)})
      else $error("pair shown outside normal view");
   a_blank_ctrl: assert property (@(posedge clk_sys) disable iff (rst)
      dispBlank == $past(ctrl_reg[CTRL_BLANK]) && dispRotate == $past(ctrl_reg[CTRL_ROT]))
      else $error("blank or rotate not applied");
endmodule : sidc_top

// File: sidc_pkg.sv
// Constants, codes and register map of the status indicator and display block
package sidc_pkg;
   // Clock and timing, times in their own units
   localparam int unsigned CLK_HZ      = 100_000_000;
   localparam int unsigned REC_TIME_S  = 10;
   localparam int unsigned FREE_TIME_S = 5;
   localparam int unsigned BLINK_MS    = 250;
   localparam int unsigned ITEM_MS     = 1000;
   localparam int unsigned REC_CYC     = REC_TIME_S * CLK_HZ;
   localparam int unsigned FREE_CYC    = FREE_TIME_S * CLK_HZ;
   localparam int unsigned BLINK_CYC   = BLINK_MS * (CLK_HZ / 1000);
   localparam int unsigned ITEM_CYC    = ITEM_MS * (CLK_HZ / 1000);

   // Geometry
   localparam int unsigned DISP_CHARS = 24;
   localparam int unsigned NCH        = 2;

   // APB register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_IRQS = 8'h08;
   localparam logic [7:0] OFS_IRQM = 8'h0c;
   localparam logic [7:0] OFS_DIAG = 8'h10;

   // Field positions and reset values
   localparam int unsigned CTRL_BLANK = 0;
   localparam int unsigned CTRL_ROT   = 1;
   localparam int unsigned IRQ_DIAG   = 0;
   localparam int unsigned IRQ_LOCK   = 1;
   localparam int unsigned IRQ_REC    = 2;
   localparam int unsigned IRQ_PING   = 3;
   localparam int unsigned IRQ_W      = 4;
   localparam logic [1:0]  CTRL_RST   = 2'h0;
   localparam logic [3:0]  IRQM_RST   = 4'h0;

   // Display content codes; 0 to 5 equal the boot item index on purpose
   localparam logic [3:0] SRC_TYPE   = 4'h0;
   localparam logic [3:0] SRC_SW     = 4'h1;
   localparam logic [3:0] SRC_SN     = 4'h2;
   localparam logic [3:0] SRC_NAME   = 4'h3;
   localparam logic [3:0] SRC_IP     = 4'h4;
   localparam logic [3:0] SRC_WLS    = 4'h5;
   localparam logic [3:0] SRC_CFGREQ = 4'h6;
   localparam logic [3:0] SRC_DATE   = 4'h7;
   localparam logic [3:0] SRC_SIG    = 4'h8;
   localparam logic [3:0] SRC_LEVEL  = 4'h9;
   localparam logic [3:0] SRC_PAIR   = 4'ha;
   localparam logic [3:0] SRC_PEND   = 4'hb;
   localparam logic [3:0] SRC_XFER   = 4'hc;
   localparam logic [3:0] SRC_PING   = 4'hd;
   localparam logic [3:0] SRC_DIAG   = 4'he;

   // Boot item indices
   localparam logic [3:0] BOOT_I_CFG   = 4'h6;
   localparam logic [3:0] BOOT_I_SIG   = 4'h7;
   localparam logic [3:0] BOOT_I_LVL   = 4'h8;
   localparam logic [3:0] BOOT_LAST_NC = 4'h6;
   localparam logic [3:0] BOOT_LAST_C  = 4'h8;

   // Diagnostic classes and message origins
   localparam logic [2:0] CLS_F    = 3'h0;
   localparam logic [2:0] CLS_E    = 3'h1;
   localparam logic [2:0] CLS_U    = 3'h2;
   localparam logic [2:0] CLS_I    = 3'h3;
   localparam logic [2:0] CLS_P    = 3'h4;
   localparam logic [1:0] ORIG_A   = 2'h0;
   localparam logic [1:0] ORIG_B   = 2'h1;
   localparam logic [1:0] ORIG_DEV = 2'h2;

   typedef enum logic {SIDC_BOOT, SIDC_RUN} sidc_state_t;
endpackage : sidc_pkg

// File: test_sidc_top.sv
// Self-checking bench for the indicator lights, display selection and APB registers
`timescale 1ns/100ps
module test_sidc_top;
   import sidc_pkg::*;
   // Short counts keep the run brief; every expectation derives from these
   localparam int REC   = 200;
   localparam int FREE  = 100;
   localparam int BLINK = 4;
   localparam int ITEM  = 20;
   logic              clk_sys, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]        paddr, pairA, pairB, angleH, angleV;
   logic [31:0]       pwdata, prdata;
   logic [NCH-1:0]    chanOn, safeOutOn, chanErr, interlockOn, interlockBlocked, protOcc, warnOcc;
   logic [NCH-1:0]    ledRed, ledGreen, ledYellow, ledBlue;
   logic              bootDone, cfgPresent, xferPending, xferConfirmed, xferActive, pingReq;
   logic              diagValid, diagLocking, dispBlank, dispRotate, recoverReq, irq;
   logic [2:0]        diagClass;
   logic [9:0]        diagCode;
   logic [1:0]        diagOrigin;
   logic [3:0]        dispSrc;
   logic [15:0]       dispArg;
   int                errCount, checks;

   sidc_top #(.REC_CYCLES(REC), .FREE_CYCLES(FREE), .BLINK_CYCLES(BLINK), .ITEM_CYCLES(ITEM)) sidc_top_i (
      .clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chanOn(chanOn), .safeOutOn(safeOutOn),
      .chanErr(chanErr), .interlockOn(interlockOn), .interlockBlocked(interlockBlocked),
      .protOcc(protOcc), .warnOcc(warnOcc),
      .pairA(pairA), .pairB(pairB), .angleH(angleH), .angleV(angleV), .bootDone(bootDone),
      .cfgPresent(cfgPresent), .xferPending(xferPending), .xferConfirmed(xferConfirmed),
      .xferActive(xferActive), .pingReq(pingReq), .diagValid(diagValid), .diagClass(diagClass),
      .diagCode(diagCode), .diagOrigin(diagOrigin), .diagLocking(diagLocking), .ledRed(ledRed),
      .ledGreen(ledGreen), .ledYellow(ledYellow), .ledBlue(ledBlue), .dispSrc(dispSrc), .dispArg(dispArg),
      .dispBlank(dispBlank), .dispRotate(dispRotate), .recoverReq(recoverReq), .irq(irq));

   // 100 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", checks, errCount);
      if (errCount == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errCount++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc

   // One APB transfer; called just after a rising edge, holds the request until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
      if (n >= 50) chk(32'h0, 32'h1);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   // Read and compare under a mask, also checking the error response
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input logic ee);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r & m, exp);
      chk({31'h0, e}, {31'h0, ee});
   endtask : rd

   // Waits a bounded time for a display content, then compares it
   task automatic waitSrc(input logic [3:0] s, input int lim);
      int n;
      n = 0;
      while (dispSrc !== s && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      chk({28'h0, dispSrc}, {28'h0, s});
   endtask : waitSrc

   task automatic pulseDiag(input logic [2:0] c, input logic [9:0] code, input logic [1:0] o, input logic lk);
      diagValid <= 1'b1;
      diagClass <= c;
      diagCode <= code;
      diagOrigin <= o;
      diagLocking <= lk;
      @(posedge clk_sys);
      diagValid <= 1'b0;
   endtask : pulseDiag

   // Error flashing and occupied-field flashing must run from one divider
   task automatic blinkSeen;
      int   t;
      logic p;
      t = 0;
      p = ledRed[0];
      repeat (3 * BLINK) begin
         @(posedge clk_sys);
         if (ledRed[0] !== p) t++;
         p = ledRed[0];
         chk({31'h0, ledRed[0]}, {31'h0, ledYellow[1]});
      end
      chk(t, 3);
   endtask : blinkSeen

   initial begin
      #100us;
      errCount++;
      complete_run();
   end

   initial begin
      int n;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {chanOn, safeOutOn, chanErr, interlockOn, interlockBlocked, protOcc, warnOcc} = '0;
      {bootDone, cfgPresent, xferPending, xferConfirmed, xferActive, pingReq} = '0;
      {diagValid, diagClass, diagCode, diagOrigin, diagLocking} = '0;
      {pairA, pairB, angleH, angleV} = 32'h1123fd09;
      rst = 1'b1;
      errCount = 0;
      checks = 0;
      cyc(12);
      chk(dispSrc, SRC_TYPE);
      rst <= 1'b0;
      cyc(1);
      rd(OFS_CTRL, 32'h0, 32'hffffffff, 1'b0);
      rd(OFS_IRQM, 32'h0, 32'hffffffff, 1'b0);
      rd(8'h20, 32'h0, 32'hffffffff, 1'b1);
      wr(OFS_CTRL, 32'h3);
      cyc(1);
      chk({dispBlank, dispRotate}, 2'b11);
      wr(OFS_CTRL, 32'h0);
      // Light patterns for both channels
      chanOn <= 2'b11;
      safeOutOn <= 2'b01;
      warnOcc <= 2'b10;
      interlockOn <= 2'b11;
      interlockBlocked <= 2'b01;
      cyc(2);
      chk(ledGreen, 2'b01);
      chk(ledRed, 2'b10);
      chk(ledBlue, 2'b10);
      chk(ledYellow, 2'b01);
      chanOn <= 2'b01;
      cyc(2);
      chk({ledRed[1], ledGreen[1], ledYellow[1], ledBlue[1]}, 4'h0);
      chanOn <= 2'b11;
      chanErr <= 2'b01;
      protOcc <= 2'b10;
      cyc(2);
      blinkSeen();
      chanErr <= 2'b00;
      protOcc <= 2'b00;
      // Unconfigured start-up cycles and wraps, then shows the angles
      waitSrc(SRC_CFGREQ, 8 * ITEM);
      waitSrc(SRC_TYPE, ITEM + 2);
      bootDone <= 1'b1;
      cyc(3);
      chk(dispSrc, SRC_LEVEL);
      chk(dispArg, {angleH, angleV});
      xferPending <= 1'b1;
      cyc(3);
      chk(dispSrc, SRC_PEND);
      xferConfirmed <= 1'b1;
      xferActive <= 1'b1;
      cyc(3);
      chk(dispSrc, SRC_XFER);
      wr(OFS_IRQM, 32'h9);
      // Every class while a transfer banner is also pending
      for (int c = 0; c < 5; c++) begin
         pulseDiag(c[2:0], 10'h100 + c[9:0], c[1:0] % 2'd3, 1'b0);
         cyc(2);
         chk(dispSrc, SRC_DIAG);
         chk(dispArg, {1'b0, c[1:0] % 2'd3, c[2:0], 10'h100 + c[9:0]});
         chk({31'h0, irq}, 32'h1);
         rd(OFS_DIAG, {17'h0, c[1:0] % 2'd3, c[2:0], 10'h100 + c[9:0]}, 32'hffffffff, 1'b0);
      end
      {xferPending, xferConfirmed, xferActive} <= 3'b000;
      pulseDiag(CLS_E, 10'h07b, ORIG_A, 1'b0);
      // Field stays occupied through the error so the free time starts at its release
      protOcc <= 2'b01;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (recoverReq !== 1'b1 && n < REC + 10);
      chk(n >= REC && n <= REC + 2, 1);
      protOcc <= 2'b00;
      cyc(FREE - 10);
      chk(dispSrc, SRC_DIAG);
      waitSrc(SRC_LEVEL, 30);
      pingReq <= 1'b1;
      cyc(1);
      pingReq <= 1'b0;
      cyc(2);
      chk(dispSrc, SRC_PING);
      rd(OFS_IRQS, 32'hd, 32'hf, 1'b0);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_IRQM, 32'h0);
      cyc(1);
      chk({31'h0, irq}, 32'h0);
      wr(OFS_IRQS, 32'hf);
      rd(OFS_IRQS, 32'h0, 32'hf, 1'b0);
      // A locking error never recovers by itself
      pulseDiag(CLS_F, 10'h3ff, ORIG_DEV, 1'b1);
      protOcc <= 2'b10;
      cyc(2);
      rd(OFS_STAT, 32'h1, 32'h1, 1'b0);
      blinkSeen();
      n = 0;
      repeat (REC + 20) begin
         @(posedge clk_sys);
         if (recoverReq === 1'b1) n++;
      end
      chk(n, 0);
      rd(OFS_STAT, 32'h1, 32'h1, 1'b0);
      // Power cycle with a configuration present
      rst <= 1'b1;
      bootDone <= 1'b0;
      cfgPresent <= 1'b1;
      protOcc <= 2'b00;
      cyc(3);
      rst <= 1'b0;
      cyc(1);
      rd(OFS_STAT, 32'h0, 32'h1, 1'b0);
      waitSrc(SRC_SIG, 10 * ITEM);
      waitSrc(SRC_LEVEL, ITEM + 2);
      bootDone <= 1'b1;
      cyc(3);
      chk(dispSrc, SRC_PAIR);
      chk(dispArg, {pairA, pairB});
      complete_run();
   end
endmodule : test_sidc_top
